// *** design/event_action_sequencer.sv ***
// event/action sequencer with apb registers and start/stop handling
`timescale 1ns/10ps
module event_action_sequencer (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic                        start_pin,
  input  wire logic                        stop_pin,
  input  wire logic                        at_reference,
  input  wire logic                        ramp_done,
  output logic      [seq_pkg::pct_w-1:0]   speed_ref,
  output logic                             run_cmd,
  output logic                             ramp_down,
  output logic                             free_run
);

  // ******************************
  // registers and internal state
  // ******************************
  logic                          mode_on;
  logic [seq_pkg::idx_w-1:0]     pair_count;
  logic [seq_pkg::scan_w-1:0]    scan_period;
  logic [seq_pkg::timer_w-1:0]   timer0_load;
  logic [seq_pkg::pct_w-1:0]     preset0;
  logic [seq_pkg::pct_w-1:0]     preset1;
  logic [seq_pkg::din_w-1:0]     start_func;
  logic [seq_pkg::din_w-1:0]     stop_func;
  logic [seq_pkg::idx_w-1:0]     state_idx;
  logic [seq_pkg::timer_w-1:0]   timer0;
  logic                          timer0_run;
  logic                          timer0_out;
  logic                          scan;
  logic [2*seq_pkg::code_w-1:0]  pair_rd;
  logic [1:0]                    start_sync;
  logic [1:0]                    stop_sync;
  logic                          start_q;
  logic                          latched;
  logic                          event_hit;
  logic                          start_req;
  logic                          stop_req;
  seq_pkg::drv_state_t           drv;
  seq_pkg::drv_state_t           next_drv;
  logic [seq_pkg::code_w-1:0]    cur_event;
  logic [seq_pkg::code_w-1:0]    cur_action;
  logic                          wr_acc;
  logic                          table_hit;
  logic [7:0]                    table_off;
  logic [seq_pkg::idx_w-1:0]     wr_idx;
  logic                          action_go;

  assign wr_acc    = psel && penable && pwrite;
  // table words are write only: reading one gives zero and no error
  assign table_hit = (paddr >= seq_pkg::table_base) && (paddr <= seq_pkg::table_end)
                     && (paddr[1:0] == 2'b00);
  assign table_off = paddr - seq_pkg::table_base;
  assign wr_idx    = table_off[2+seq_pkg::idx_w-1:2];

  // ******************************
  // pair storage and scan strobe
  // ******************************
  pair_table u_table (
    .pclk    (pclk),
    .wr_en   (wr_acc && table_hit),
    .wr_idx  (wr_idx),
    .wr_data (pwdata[2*seq_pkg::code_w-1:0]),
    .rd_idx  (state_idx),
    .rd_data (pair_rd)
  );

  scan_strobe u_scan (
    .pclk    (pclk),
    .presetn (presetn),
    .period  (scan_period),
    .strobe  (scan)
  );

  // table word: event in bits 5:0, action in bits 11:6
  assign cur_event  = pair_rd[seq_pkg::code_w-1:0];
  assign cur_action = pair_rd[2*seq_pkg::code_w-1:seq_pkg::code_w];

  // ******************************
  // apb slave, zero wait states
  // ******************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_on     <= 1'b0;
      pair_count  <= '0;
      scan_period <= seq_pkg::scan_reset;
      timer0_load <= seq_pkg::timer_reset;
      preset0     <= '0;
      preset1     <= '0;
      start_func  <= seq_pkg::din_start;
      stop_func   <= seq_pkg::din_no_op;
    end else if (wr_acc) begin
      case (paddr)
        seq_pkg::ctrl_addr: begin
          mode_on <= pwdata[seq_pkg::ctrl_mode_bit];
        end
        seq_pkg::count_addr: begin
          // counts beyond the table are clamped so the index stays in range
          if (pwdata > 32'(seq_pkg::pairs_max)) begin
            pair_count <= 5'(seq_pkg::pairs_max);
          end else begin
            pair_count <= pwdata[seq_pkg::idx_w-1:0];
          end
        end
        seq_pkg::scan_addr: begin
          scan_period <= pwdata[seq_pkg::scan_w-1:0];
        end
        seq_pkg::timer_addr: begin
          timer0_load <= pwdata[seq_pkg::timer_w-1:0];
        end
        seq_pkg::preset0_addr: begin
          // the whole word is compared so a large value cannot wrap below the limit
          preset0 <= (pwdata > 32'(seq_pkg::ref_max_pct)) ? seq_pkg::ref_max_pct
                     : pwdata[seq_pkg::pct_w-1:0];
        end
        seq_pkg::preset1_addr: begin
          preset1 <= (pwdata > 32'(seq_pkg::ref_max_pct)) ? seq_pkg::ref_max_pct
                     : pwdata[seq_pkg::pct_w-1:0];
        end
        seq_pkg::din_addr: begin
          start_func <= pwdata[3:0];
          stop_func  <= pwdata[7:4];
        end
        default: begin
        end
      endcase
    end
  end

  // ******************************
  // register read, answered in the first access cycle
  // ******************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable) begin
        case (paddr)
          seq_pkg::ctrl_addr:    prdata <= {31'h00000000, mode_on};
          seq_pkg::status_addr:  prdata <= {20'h00000, drv, timer0_run, timer0_out,
                                           3'h0, state_idx};
          seq_pkg::count_addr:   prdata <= {27'h0000000, pair_count};
          seq_pkg::scan_addr:    prdata <= {16'h0000, scan_period};
          seq_pkg::timer_addr:   prdata <= {8'h00, timer0_load};
          seq_pkg::preset0_addr: prdata <= {25'h0000000, preset0};
          seq_pkg::preset1_addr: prdata <= {25'h0000000, preset1};
          seq_pkg::din_addr:     prdata <= {24'h000000, stop_func, start_func};
          default: begin
            pslverr <= !table_hit;
          end
        endcase
      end
    end
  end

  // ******************************
  // sequencer core
  // ******************************
  // only the event at state_idx is decoded; unknown codes read false
  always_comb begin
    case (cur_event)
      seq_pkg::ev_false:    event_hit = 1'b0;
      seq_pkg::ev_true:     event_hit = 1'b1;
      seq_pkg::ev_on_ref:   event_hit = at_reference;
      seq_pkg::ev_timeout0: event_hit = timer0_out;
      default:              event_hit = 1'b0;
    endcase
  end

  // the table read lags a cycle; the strobe period is long so data is settled
  // a scan period of zero would act on the previous pair's codes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_idx <= '0;
    end else if (!mode_on || pair_count == 5'h00) begin
      state_idx <= '0;
    end else if (scan && event_hit) begin
      if (state_idx >= pair_count - 5'h01) begin
        state_idx <= '0;
      end else begin
        state_idx <= state_idx + 5'h01;
      end
    end
  end

  // ******************************
  // action execution
  // ******************************
  // one action per taken scan; the same strobe edge moves the index
  assign action_go = mode_on && (pair_count != 5'h00) && scan && event_hit;

  // the reference only moves on a taken action, so it stands between scans
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_ref <= '0;
    end else if (action_go) begin
      case (cur_action)
        seq_pkg::act_preset0: speed_ref <= preset0;
        seq_pkg::act_preset1: speed_ref <= preset1;
        default: begin
        end
      endcase
    end
  end

  // restarting the timer clears an old expiry so the next timeout event waits again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer0     <= '0;
      timer0_run <= 1'b0;
      timer0_out <= 1'b0;
    end else if (action_go && (cur_action == seq_pkg::act_timer0)) begin
      timer0     <= timer0_load;
      timer0_run <= 1'b1;
      timer0_out <= 1'b0;
    end else if (timer0_run) begin
      if (timer0 == '0) begin
        timer0_run <= 1'b0;
        timer0_out <= 1'b1;
      end else begin
        timer0 <= timer0 - 24'h000001;
      end
    end
  end

  // ******************************
  // start/stop inputs and drive state
  // ******************************
  // pins are asynchronous: only the second flop of each pair feeds any logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_sync <= 2'b00;
      stop_sync  <= 2'b00;
      start_q    <= 1'b0;
    end else begin
      start_sync <= {start_sync[0], start_pin};
      stop_sync  <= {stop_sync[0], stop_pin};
      start_q    <= start_sync[1];
    end
  end

  // start function: level start holds, latched start catches a rising edge
  always_comb begin
    case (start_func)
      seq_pkg::din_start:    start_req = start_sync[1];
      seq_pkg::din_latch_st: start_req = latched || (start_sync[1] && !start_q);
      default:               start_req = 1'b0;
    endcase
    case (stop_func)
      seq_pkg::din_stop_inv: stop_req = !stop_sync[1];
      // no stop function: releasing a level start is the stop
      default:               stop_req = (start_func == seq_pkg::din_start) && !start_sync[1];
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched <= 1'b0;
    end else if (start_sync[1] && !start_q) begin
      // a start edge wins over a stop in one cycle; a held stop clears it next cycle
      latched <= 1'b1;
    end else if (stop_req) begin
      latched <= 1'b0;
    end
  end

  // ******************************
  // drive state
  // ******************************
  // a held stop keeps the drive from starting, whatever the start input does
  always_comb begin
    next_drv = drv;
    case (drv)
      seq_pkg::drv_idle: begin
        if (start_req && !stop_req) begin
          next_drv = seq_pkg::drv_run;
        end
      end
      seq_pkg::drv_run: begin
        if (stop_req) begin
          next_drv = seq_pkg::drv_rampd;
        end
      end
      seq_pkg::drv_rampd: begin
        if (ramp_done) begin
          next_drv = seq_pkg::drv_free;
        end
      end
      seq_pkg::drv_free: begin
        if (start_req && !stop_req) begin
          next_drv = seq_pkg::drv_run;
        end
      end
      default: begin
        next_drv = seq_pkg::drv_idle;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv       <= seq_pkg::drv_idle;
      run_cmd   <= 1'b0;
      ramp_down <= 1'b0;
      free_run  <= 1'b0;
    end else begin
      drv       <= next_drv;
      run_cmd   <= (next_drv == seq_pkg::drv_run);
      ramp_down <= (next_drv == seq_pkg::drv_rampd);
      free_run  <= (next_drv == seq_pkg::drv_free);
    end
  end

endmodule

// *** design/pair_table.sv ***
// twenty-entry storage of event/action code pairs
`timescale 1ns/10ps
module pair_table (
  input  wire logic                          pclk,
  input  wire logic                          wr_en,
  input  wire logic [seq_pkg::idx_w-1:0]     wr_idx,
  input  wire logic [2*seq_pkg::code_w-1:0]  wr_data,
  input  wire logic [seq_pkg::idx_w-1:0]     rd_idx,
  output logic      [2*seq_pkg::code_w-1:0]  rd_data
);

  logic [2*seq_pkg::code_w-1:0] mem [seq_pkg::pairs_max];

  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // registered read; index is always below pairs_max by construction
  always_ff @(posedge pclk) begin
    rd_data <= mem[rd_idx];
  end

endmodule

// *** design/scan_strobe.sv ***
// periodic scan strobe generator
`timescale 1ns/10ps
module scan_strobe (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic [seq_pkg::scan_w-1:0] period,
  output logic                            strobe
);

  logic [seq_pkg::scan_w-1:0] count;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count  <= '0;
      strobe <= 1'b0;
    end else if (count >= period) begin
      count  <= '0;
      strobe <= 1'b1;
    end else begin
      count  <= count + 16'h0001;
      strobe <= 1'b0;
    end
  end

endmodule

// *** design/seq_pkg.sv ***
// constants shared by the event/action sequencer design
package seq_pkg;

  // ******************************
  // register map (word aligned byte offsets)
  // ******************************
  localparam logic [7:0] ctrl_addr    = 8'h00;
  localparam logic [7:0] status_addr  = 8'h04;
  localparam logic [7:0] count_addr   = 8'h08;
  localparam logic [7:0] scan_addr    = 8'h0C;
  localparam logic [7:0] timer_addr   = 8'h10;
  localparam logic [7:0] preset0_addr = 8'h14;
  localparam logic [7:0] preset1_addr = 8'h18;
  localparam logic [7:0] din_addr     = 8'h1C;
  localparam logic [7:0] table_base   = 8'h40;
  localparam logic [7:0] table_end    = 8'h8C;

  // ******************************
  // field positions and reset values
  // ******************************
  localparam int ctrl_mode_bit  = 0;
  localparam int ev_lsb         = 0;
  localparam int act_lsb        = 8;
  localparam int code_w         = 6;
  localparam int idx_w          = 5;
  localparam int pairs_max      = 20;
  localparam int scan_w         = 16;
  localparam int timer_w        = 24;
  localparam int pct_w          = 7;
  localparam int din_w          = 4;
  localparam logic [scan_w-1:0]  scan_reset  = 16'h03E8;
  localparam logic [timer_w-1:0] timer_reset = 24'h000014;
  localparam logic [pct_w-1:0]   ref_max_pct = 7'h64;

  // ******************************
  // event, action and digital input codes
  // ******************************
  localparam logic [code_w-1:0] ev_false      = 6'h00;
  localparam logic [code_w-1:0] ev_true       = 6'h01;
  localparam logic [code_w-1:0] ev_on_ref     = 6'h04;
  localparam logic [code_w-1:0] ev_timeout0   = 6'h1E;
  localparam logic [code_w-1:0] act_none      = 6'h01;
  localparam logic [code_w-1:0] act_preset0   = 6'h0A;
  localparam logic [code_w-1:0] act_preset1   = 6'h0B;
  localparam logic [code_w-1:0] act_timer0    = 6'h1D;
  localparam logic [din_w-1:0]  din_no_op     = 4'h0;
  localparam logic [din_w-1:0]  din_stop_inv  = 4'h6;
  localparam logic [din_w-1:0]  din_start     = 4'h8;
  localparam logic [din_w-1:0]  din_latch_st  = 4'h9;

  typedef enum logic [1:0] {
    drv_idle  = 2'b00,
    drv_run   = 2'b01,
    drv_rampd = 2'b10,
    drv_free  = 2'b11
  } drv_state_t;

endpackage

// *** tb/drv_model.sv ***
// drive core stand-in: reports on-reference and ramp finished
`timescale 1ns/10ps
module drv_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run_cmd,
  input  wire logic ramp_down,
  output logic      at_reference,
  output logic      ramp_done
);
  // ************************
  // ramp timing
  // ************************
  logic [3:0] up_cnt, dn_cnt;
  // short fixed ramps keep the scan waits small
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) up_cnt <= 4'h0;
    else if (!run_cmd) up_cnt <= 4'h0;
    else if (up_cnt != 4'hF) up_cnt <= up_cnt + 4'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dn_cnt <= 4'h0;
    else if (!ramp_down) dn_cnt <= 4'h0;
    else if (dn_cnt != 4'hF) dn_cnt <= dn_cnt + 4'h1;
  end
  assign at_reference = run_cmd && up_cnt > 4'h8;
  assign ramp_done    = ramp_down && dn_cnt > 4'h5;
endmodule

// *** tb/seq_monitor.sv ***
// port assertions for the event/action sequencer
`timescale 1ns/10ps
module seq_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic [6:0]  speed_ref,
  input wire logic        run_cmd,
  input wire logic        ramp_down,
  input wire logic        free_run
);
  // ************************
  // checks
  // ************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("answer held");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error outside answer");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  a_drive_onehot: assert property ($onehot0({run_cmd, ramp_down, free_run}))
    else $error("drive state not one-hot");
  a_ramp_run: assert property ($rose(ramp_down) |-> $past(run_cmd))
    else $error("ramp without run");
  a_free_ramp: assert property ($rose(free_run) |-> $past(ramp_down))
    else $error("free run without ramp");
  a_ref_range: assert property (speed_ref <= 7'h64)
    else $error("reference above maximum");
  a_ref_spacing: assert property ($changed(speed_ref) |=> $stable(speed_ref))
    else $error("reference moved twice");
  cover property (pslverr);
  cover property (speed_ref == 7'h3C);
  cover property (ramp_down ##1 free_run);
endmodule

bind event_action_sequencer seq_monitor u_seq_monitor (.pclk, .presetn, .psel, .penable,
  .pready, .pslverr, .prdata, .speed_ref, .run_cmd, .ramp_down, .free_run);

// *** tb/testbench.sv ***
// self-checking bench for the event/action sequencer
`timescale 1ns/10ps
module testbench;
  logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]                paddr;
  logic [31:0]               pwdata, prdata, rd;
  logic                      start_pin, stop_pin, at_reference, ramp_done;
  logic [seq_pkg::pct_w-1:0] speed_ref;
  logic                      run_cmd, ramp_down, free_run;
  int                        mismatches, checks_done, cyc;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d, e; logic r;} row_t;
  row_t                      rows[13];
  logic [11:0]               prog[4];

  event_action_sequencer u_event_action_sequencer (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .start_pin(start_pin),
    .stop_pin(stop_pin), .at_reference(at_reference), .ramp_done(ramp_done),
    .speed_ref(speed_ref), .run_cmd(run_cmd), .ramp_down(ramp_down), .free_run(free_run));
  drv_model u_drv_model (.pclk(pclk), .presetn(presetn), .run_cmd(run_cmd),
    .ramp_down(ramp_down), .at_reference(at_reference), .ramp_done(ramp_done));

  // ************************
  // helpers
  // ************************
  initial begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      test_done;
    end
  end
  task check(input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // bounded wait on masked {speed_ref, run_cmd, ramp_down, free_run}
  task wait_out(input logic [9:0] v, m);
    int n;
    n = 0;
    while ((({speed_ref, run_cmd, ramp_down, free_run} & m) !== v) && n < 400) begin
      @(posedge pclk);
      n++;
    end
    check({speed_ref, run_cmd, ramp_down, free_run} & m, v);
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ************************
  // main sequence
  // ************************
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    start_pin = 0; stop_pin = 0;
    rows = '{'{0, seq_pkg::ctrl_addr, 0, 0, 0}, '{0, seq_pkg::count_addr, 0, 0, 0},
      '{0, seq_pkg::scan_addr, 0, 32'h3E8, 0}, '{0, seq_pkg::timer_addr, 0, 32'h14, 0},
      '{0, seq_pkg::preset0_addr, 0, 0, 0}, '{0, seq_pkg::din_addr, 0, 32'h08, 0},
      '{0, 8'h30, 0, 0, 1}, '{1, seq_pkg::count_addr, 32'h19, 32'h14, 0},
      '{1, seq_pkg::preset0_addr, 32'h96, 32'h64, 0}, '{1, seq_pkg::din_addr, 32'h69, 32'h69, 0},
      '{1, seq_pkg::din_addr, 32'h08, 32'h08, 0}, '{1, 8'h30, 32'h5, 0, 1},
      '{1, seq_pkg::table_base, 32'h41, 0, 0}};
    prog = '{{seq_pkg::act_preset0, seq_pkg::ev_true}, {seq_pkg::act_timer0, seq_pkg::ev_on_ref},
      {seq_pkg::act_preset1, seq_pkg::ev_timeout0}, {seq_pkg::act_none, seq_pkg::ev_false}};
    repeat (16) @(posedge pclk);
    check({speed_ref, run_cmd, ramp_down, free_run}, 0);
    presetn <= 1;
    foreach (rows[i]) begin
      if (rows[i].w) apb(1, rows[i].a, rows[i].d);
      apb(0, rows[i].a, 32'h0);
      check(rd, rows[i].e);
      check(er, rows[i].r);
    end
    $display("done: registers");
    apb(1, seq_pkg::scan_addr, 32'h4);
    apb(1, seq_pkg::preset0_addr, 32'h3C);
    apb(1, seq_pkg::preset1_addr, 32'h0);
    apb(1, seq_pkg::count_addr, 32'h4);
    for (int i = 0; i < 4; i++) apb(1, seq_pkg::table_base + 8'(4 * i), {20'h0, prog[i]});
    start_pin <= 1;
    wait_out(10'h004, 10'h007);
    repeat (30) @(posedge pclk);
    check(speed_ref, 0);
    apb(0, seq_pkg::status_addr, 0);
    check(rd[4:0], 0);
    apb(1, seq_pkg::ctrl_addr, 32'h1);
    wait_out({7'h3C, 3'h0}, 10'h3F8);
    wait_out(10'h000, 10'h3F8);
    repeat (12) @(posedge pclk);
    apb(0, seq_pkg::status_addr, 0);
    check(rd[4:0], 5'h3);
    repeat (20) @(posedge pclk);
    apb(0, seq_pkg::status_addr, 0);
    check(rd[4:0], 5'h3);
    check(speed_ref, 0);
    $display("done: sequence");
    apb(1, seq_pkg::table_base + 8'hC, {20'h0, seq_pkg::act_none, seq_pkg::ev_true});
    wait_out({7'h3C, 3'h0}, 10'h3F8);
    apb(1, seq_pkg::ctrl_addr, 32'h0);
    start_pin <= 0;
    wait_out(10'h002, 10'h007);
    wait_out(10'h001, 10'h007);
    $display("done: stop");
    start_pin <= 1;
    wait_out(10'h004, 10'h007);
    stop_pin <= 1;
    apb(1, seq_pkg::din_addr, 32'h69);
    start_pin <= 0;
    repeat (10) @(posedge pclk);
    check(run_cmd, 1);
    stop_pin <= 0;
    wait_out(10'h002, 10'h007);
    wait_out(10'h001, 10'h007);
    stop_pin <= 1;
    repeat (10) @(posedge pclk);
    check(free_run, 1);
    start_pin <= 1;
    repeat (4) @(posedge pclk);
    start_pin <= 0;
    wait_out(10'h004, 10'h007);
    repeat (10) @(posedge pclk);
    check(run_cmd, 1);
    $display("done: latched start");
    presetn <= 0;
    @(posedge pclk);
    check({speed_ref, run_cmd, ramp_down, free_run}, 0);
    presetn <= 1;
    apb(0, seq_pkg::count_addr, 0);
    check(rd, 0);
    $display("done: reset");
    test_done;
  end
endmodule
